// ---- hw/cxe_params.svh ----
`ifndef CXE_PARAMS_SVH
`define CXE_PARAMS_SVH
// =============================================
// register offsets (byte addresses)
`define CXE_OFF_STATUS_WORD 12'h000
`define CXE_OFF_VECTOR_BASE 12'h004
`define CXE_OFF_STACK_PTR 12'h008
`define CXE_OFF_PROG_COUNT 12'h00c
`define CXE_OFF_ENTRY_INFO 12'h010
// =============================================
// status word layout and reset values
`define CXE_IMASK_LSB 4
`define CXE_IMASK_MSB 7
`define CXE_IMASK_ALL 4'hf
`define CXE_STATUS_RST 32'h000000f0
`define CXE_VBASE_RST 32'h00000000
`define CXE_LONG_BYTES 32'h00000004
// =============================================
// vector numbers
`define CXE_VEC_POR_PROG 8'h00
`define CXE_VEC_MAN_PROG 8'h02
`define CXE_VEC_STACK_STEP 8'h01
`define CXE_VEC_GEN_ILL 8'h04
`define CXE_VEC_SLOT_ILL 8'h06
`define CXE_VEC_AE_CPU 8'h09
`define CXE_VEC_AE_XFER 8'h0a
`define CXE_VEC_TRAP_LO 8'h20
`define CXE_VEC_TRAP_HI 8'h3f
`define CXE_VEC_PERI_LO 8'h48
`define CXE_VEC_PERI_HI 8'hff
`endif

// ---- hw/cxe_pkg.sv ----
package cxe_pkg;
   // =============================================
   // entry sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HOLD,
      ST_RST_PROG,
      ST_RST_STACK,
      ST_PUSH_STATUS,
      ST_PUSH_RET,
      ST_VEC_READ
   } cxe_state_type;
endpackage : cxe_pkg

// ---- hw/cxe_sync.sv ----
`timescale 1ns/1ps
module cxe_sync
#(
   parameter int WIDTH = 2
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // raw pin levels and their synchronised copies
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // =============================================
   // two-stage synchroniser
   logic [WIDTH-1:0] meta_q;

   // pins read as low (in reset) until the first samples arrive
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         dout <= '0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule : cxe_sync

// ---- hw/cxe_entry.sv ----
// Overview of operation
// [RQ1] power-on entry starts on reset pin rising or watchdog overflow
// [RQ2] manual entry starts on manual reset pin rising
// [RQ3] address error caught at decode, taken after previous instruction ends
// [RQ4] trap-always instruction starts trap entry
// [RQ5] undefined opcode outside a delay slot gives general illegal entry
// [RQ6] undefined or flow-changing opcode in delay slot gives slot illegal
// [RQ7] resets load counter and stack from 0x0/0x4 or 0x8/0xC
// [RQ8] reset clears vector base and sets interrupt mask field to all ones
// [RQ9] after reset, fetch starts at the loaded program counter
// [RQ10] other entries push status word and counter on the stack
// [RQ11] interrupt entry writes accepted level into interrupt mask field
// [RQ12] address error and instruction entries leave the mask untouched
// [RQ13] after stacking, handler address is read and fetch resumes there
// [RQ14] reset vector address is vector number times four, no base
// [RQ15] other vector addresses are vector base plus four times number
// [RQ16] every source has its own vector number and offset
// [RQ17] vector 9 for processor address error, 10 for transfer errors
// [RQ18] trap immediates map onto vectors 32 to 63
// [RQ19] peripheral interrupts use vectors 72 to 255, one each
// [RQ20] pin reset beats simultaneous watchdog reset and clears its flag
// [RQ21] manual reset waits for a running bus cycle to finish
// [RQ22] stack predecrements by four, status word pushed before counter
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`include "cxe_params.svh"
module cxe_entry
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // reset sources
   input wire logic power_on_reset_pin_n,
   input wire logic manual_reset_pin_n,
   input wire logic watchdog_overflow,
   output logic watchdog_flag_clear,
   input wire logic bus_cycle_busy,
   // interrupt controller
   input wire logic irq_req,
   input wire logic [3:0] irq_level,
   input wire logic [7:0] irq_vector,
   output logic irq_ack,
   // instruction decoder
   input wire logic dec_valid,
   input wire logic dec_undefined,
   input wire logic dec_in_slot,
   input wire logic dec_flow_write,
   input wire logic dec_trap,
   input wire logic [7:0] dec_trap_imm,
   input wire logic addr_err_cpu,
   input wire logic addr_err_xfer,
   input wire logic prev_done,
   input wire logic [31:0] return_addr,
   // memory port
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   // fetch restart
   output logic fetch_start,
   output logic [31:0] fetch_addr
);
   // =============================================
   // state
   cxe_pkg::cxe_state_type state_q;
   logic [1:0] pin_s;
   logic [1:0] pin_q;
   logic [1:0] ae_pend_q;
   logic man_pend_q;
   logic [31:0] status_word_q;
   logic [31:0] vector_base_reg_q;
   logic [31:0] stack_pointer_q;
   logic [31:0] program_counter_q;
   logic [31:0] ret_q;
   logic [7:0] vec_q;
   logic [3:0] lvl_q;
   logic is_irq_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic wd_clear_q;
   logic irq_ack_q;
   logic mem_req_q;
   logic mem_we_q;
   logic [31:0] mem_addr_q;
   logic [31:0] mem_wdata_q;
   logic fetch_start_q;

   function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                            input logic [7:0] vec);
      vec_addr = base + {22'h000000, vec, 2'b00};
   endfunction : vec_addr

   // =============================================
   // pin synchronisers
   cxe_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din({power_on_reset_pin_n, manual_reset_pin_n}),
      .dout(pin_s)
   );

   // =============================================
   // reset decode
   wire por_low = ~pin_s[1];
   wire por_rise = pin_s[1] & ~pin_q[1];
   wire man_rise = pin_s[0] & ~pin_q[0];
   // pin reset owns the cycle; watchdog only acts with the pin high
   wire wd_clash = watchdog_overflow & (por_low | por_rise);
   wire por_go = por_rise | (watchdog_overflow & ~wd_clash);
   // our own bus cycle or a foreign one must end first
   wire man_go = man_pend_q & ~bus_cycle_busy & ~mem_req_q & ~por_go
                 & ~por_low;
   wire calm = ~por_go & ~por_low;

   // =============================================
   // exception decode
   wire idle = state_q == cxe_pkg::ST_IDLE;
   wire mem_done = mem_req_q & mem_ack;
   wire [3:0] imask = status_word_q[`CXE_IMASK_MSB:`CXE_IMASK_LSB];
   wire ae_go = (ae_pend_q != 2'b00) & prev_done;
   wire irq_go = irq_req & (irq_level > imask);
   wire slot_go = dec_valid & dec_in_slot & (dec_undefined | dec_flow_write);
   wire trap_go = dec_valid & ~dec_in_slot & dec_trap;
   wire gen_go = dec_valid & ~dec_in_slot & dec_undefined;
   wire exc_go = idle & calm & ~man_pend_q
                 & (ae_go | irq_go | slot_go | trap_go | gen_go);
   wire irq_take = exc_go & ~ae_go & irq_go;
   wire ae_take = exc_go & ae_go;
   wire [1:0] ae_clr = ae_take ? (ae_pend_q[1] ? 2'b10 : 2'b01) : 2'b00;
   wire [7:0] trap_vec = `CXE_VEC_TRAP_LO | {3'b000, dec_trap_imm[4:0]};
   wire [7:0] ae_vec = ae_pend_q[1] ? `CXE_VEC_AE_CPU : `CXE_VEC_AE_XFER;
   wire [7:0] man_vec = por_go ? `CXE_VEC_POR_PROG : `CXE_VEC_MAN_PROG;
   // fixed order: address error, interrupt, trap, slot, general
   wire [7:0] exc_vec = ae_go ? ae_vec // RQ17
                      : irq_go ? irq_vector // RQ19
                      : trap_go ? trap_vec // RQ18
                      : slot_go ? `CXE_VEC_SLOT_ILL // RQ6
                      : `CXE_VEC_GEN_ILL; // RQ16
   wire [31:0] stack_dec = stack_pointer_q - `CXE_LONG_BYTES;

   // =============================================
   // apb decode
   wire apb_setup = psel & ~penable;
   wire hit_sw = paddr == `CXE_OFF_STATUS_WORD;
   wire hit_vb = paddr == `CXE_OFF_VECTOR_BASE;
   wire hit_sp = paddr == `CXE_OFF_STACK_PTR;
   wire hit_pc = paddr == `CXE_OFF_PROG_COUNT;
   wire hit_in = paddr == `CXE_OFF_ENTRY_INFO;
   wire apb_hit = hit_sw | hit_vb | hit_sp | hit_pc | hit_in;
   // writes during an entry are dropped so stacking sees stable values
   wire apb_wr = psel & penable & pready_q & pwrite & idle;
   wire [31:0] info = {23'h000000, ~idle, vec_q};
   wire [31:0] rd_mux = hit_sw ? status_word_q
                      : hit_vb ? vector_base_reg_q
                      : hit_sp ? stack_pointer_q
                      : hit_pc ? program_counter_q
                      : hit_in ? info : 32'h00000000;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign watchdog_flag_clear = wd_clear_q;
   assign irq_ack = irq_ack_q;
   assign mem_req = mem_req_q;
   assign mem_we = mem_we_q;
   assign mem_addr = mem_addr_q;
   assign mem_wdata = mem_wdata_q;
   assign fetch_start = fetch_start_q;
   assign fetch_addr = program_counter_q;

   // =============================================
   // apb answer, one wait-free access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= apb_setup;
         pslverr_q <= apb_setup & ~apb_hit;
         if (apb_setup)
            prdata_q <= rd_mux;
      end
   end

   // =============================================
   // entry sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= cxe_pkg::ST_HOLD;
         pin_q <= 2'b00;
         ae_pend_q <= 2'b00;
         man_pend_q <= 1'b0;
         status_word_q <= `CXE_STATUS_RST;
         vector_base_reg_q <= `CXE_VBASE_RST;
         stack_pointer_q <= 32'h00000000;
         program_counter_q <= 32'h00000000;
         ret_q <= 32'h00000000;
         vec_q <= 8'h00;
         lvl_q <= 4'h0;
         is_irq_q <= 1'b0;
         wd_clear_q <= 1'b0;
         irq_ack_q <= 1'b0;
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_addr_q <= 32'h00000000;
         mem_wdata_q <= 32'h00000000;
         fetch_start_q <= 1'b0;
      end
      else
      begin
         fetch_start_q <= 1'b0;
         irq_ack_q <= 1'b0;
         pin_q <= pin_s;
         wd_clear_q <= wd_clash; // RQ20
         // a new detection wins over the clear of the same cycle
         ae_pend_q <= (ae_pend_q & ~ae_clr)
                      | {addr_err_cpu, addr_err_xfer}; // RQ3
         // power-on swallows a manual rise of the same cycle too
         man_pend_q <= ((man_pend_q & ~man_go) | man_rise) & ~por_go
                       & ~por_low; // RQ2
         if (apb_wr & hit_sw)
            status_word_q <= pwdata;
         if (apb_wr & hit_vb)
            vector_base_reg_q <= pwdata;
         if (apb_wr & hit_sp)
            stack_pointer_q <= pwdata;
         if (por_low)
         begin
            state_q <= cxe_pkg::ST_HOLD;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
         end
         else if (por_go | man_go) // RQ1 RQ21
         begin
            state_q <= cxe_pkg::ST_RST_PROG;
            vector_base_reg_q <= `CXE_VBASE_RST; // RQ8
            status_word_q[`CXE_IMASK_MSB:`CXE_IMASK_LSB]
               <= `CXE_IMASK_ALL; // RQ8
            vec_q <= man_vec;
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            mem_addr_q <= vec_addr(32'h00000000, man_vec); // RQ7 RQ14
         end
         else
         begin
            unique case (state_q)
               cxe_pkg::ST_IDLE:
                  if (exc_go) // RQ4 RQ5
                  begin
                     vec_q <= exc_vec;
                     lvl_q <= irq_level;
                     is_irq_q <= irq_take;
                     irq_ack_q <= irq_take;
                     ret_q <= return_addr;
                     stack_pointer_q <= stack_dec; // RQ22
                     mem_req_q <= 1'b1;
                     mem_we_q <= 1'b1;
                     mem_addr_q <= stack_dec;
                     mem_wdata_q <= status_word_q; // RQ10
                     state_q <= cxe_pkg::ST_PUSH_STATUS;
                  end
               cxe_pkg::ST_HOLD:
                  state_q <= cxe_pkg::ST_HOLD;
               cxe_pkg::ST_RST_PROG:
                  if (mem_done)
                  begin
                     program_counter_q <= mem_rdata;
                     mem_addr_q <= vec_addr(32'h00000000,
                        vec_q + `CXE_VEC_STACK_STEP); // RQ7
                     state_q <= cxe_pkg::ST_RST_STACK;
                  end
               cxe_pkg::ST_RST_STACK:
                  if (mem_done)
                  begin
                     stack_pointer_q <= mem_rdata;
                     mem_req_q <= 1'b0;
                     fetch_start_q <= 1'b1; // RQ9
                     state_q <= cxe_pkg::ST_IDLE;
                  end
               cxe_pkg::ST_PUSH_STATUS:
                  if (mem_done)
                  begin
                     // old mask is already stacked at this point
                     if (is_irq_q) // RQ11 RQ12
                        status_word_q[`CXE_IMASK_MSB:`CXE_IMASK_LSB]
                           <= lvl_q; // RQ11
                     stack_pointer_q <= stack_dec; // RQ22
                     mem_addr_q <= stack_dec;
                     mem_wdata_q <= ret_q; // RQ10
                     state_q <= cxe_pkg::ST_PUSH_RET;
                  end
               cxe_pkg::ST_PUSH_RET:
                  if (mem_done)
                  begin
                     mem_we_q <= 1'b0;
                     mem_addr_q <= vec_addr(vector_base_reg_q, vec_q); // RQ15
                     state_q <= cxe_pkg::ST_VEC_READ;
                  end
               cxe_pkg::ST_VEC_READ:
                  if (mem_done)
                  begin
                     program_counter_q <= mem_rdata; // RQ13
                     mem_req_q <= 1'b0;
                     fetch_start_q <= 1'b1;
                     state_q <= cxe_pkg::ST_IDLE;
                  end
               default:
                  state_q <= cxe_pkg::ST_HOLD;
            endcase
         end
      end
   end

   // =============================================
   // assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   por_entry_a: assert property ( // RQ1
      por_go |=> state_q == cxe_pkg::ST_RST_PROG && mem_addr_q == 32'h00000000)
      else $error("power-on entry not started at vector zero");
   man_entry_a: assert property ( // RQ2
      man_go |=> state_q == cxe_pkg::ST_RST_PROG && mem_addr_q == 32'h00000008)
      else $error("manual entry not started at its vector");
   rst_stack_a: assert property ( // RQ7
      state_q == cxe_pkg::ST_RST_PROG && mem_done && calm
      |=> mem_addr_q == $past(mem_addr_q) + 32'h00000004 && !mem_we_q)
      else $error("reset stack word not read after counter");
   wd_clash_a: assert property ( // RQ20
      watchdog_overflow && por_low
      |=> wd_clear_q && state_q == cxe_pkg::ST_HOLD)
      else $error("watchdog beat the reset pin");
   man_wait_a: assert property ( // RQ21
      man_pend_q && bus_cycle_busy && calm && idle
      |=> state_q != cxe_pkg::ST_RST_PROG)
      else $error("manual reset broke into a bus cycle");
   rst_init_a: assert property ( // RQ8
      state_q == cxe_pkg::ST_RST_PROG
      |-> vector_base_reg_q == 32'h00000000 && imask == 4'hf)
      else $error("reset did not set base and mask");
   rst_fetch_a: assert property ( // RQ9
      state_q == cxe_pkg::ST_RST_STACK && mem_done && calm
      |=> fetch_start_q && fetch_addr == program_counter_q
      ##1 !fetch_start_q)
      else $error("no single fetch start after reset");
   stack_first_a: assert property ( // RQ10
      exc_go |=> mem_we_q && mem_wdata_q == $past(status_word_q)
      && mem_addr_q == $past(stack_pointer_q) - 32'h00000004)
      else $error("status word not pushed first");
   push_ret_a: assert property ( // RQ22
      state_q == cxe_pkg::ST_PUSH_STATUS && mem_done && calm
      |=> mem_we_q && mem_wdata_q == ret_q
      && mem_addr_q == $past(mem_addr_q) - 32'h00000004)
      else $error("counter push not predecremented");
   irq_mask_a: assert property ( // RQ11
      state_q == cxe_pkg::ST_PUSH_STATUS && mem_done && is_irq_q && calm
      |=> imask == $past(lvl_q))
      else $error("interrupt level not written to mask");
   keep_mask_a: assert property ( // RQ12
      !idle && !is_irq_q && calm && state_q != cxe_pkg::ST_HOLD
      && state_q != cxe_pkg::ST_RST_PROG
      && state_q != cxe_pkg::ST_RST_STACK |=> $stable(imask))
      else $error("mask changed on non-interrupt entry");
   vec_read_a: assert property ( // RQ15
      state_q == cxe_pkg::ST_PUSH_RET && mem_done && calm
      |=> !mem_we_q && mem_addr_q == $past(vector_base_reg_q)
      + {22'h000000, vec_q, 2'b00})
      else $error("handler address not base plus four times vector");
   handler_a: assert property ( // RQ13
      state_q == cxe_pkg::ST_VEC_READ && mem_done && calm
      |=> fetch_start_q && program_counter_q == $past(mem_rdata))
      else $error("fetch not resumed at handler");
   ae_after_a: assert property ( // RQ3
      exc_go |=> !(vec_q == `CXE_VEC_AE_CPU || vec_q == `CXE_VEC_AE_XFER)
      || $past(prev_done))
      else $error("address error taken before previous instruction");
   trap_vec_a: assert property ( // RQ18
      exc_go && trap_go && !ae_go && !irq_go
      |=> vec_q >= `CXE_VEC_TRAP_LO && vec_q <= `CXE_VEC_TRAP_HI)
      else $error("trap vector out of user range");
   slot_vec_a: assert property ( // RQ6
      exc_go && slot_go && !ae_go && !irq_go
      |=> vec_q == `CXE_VEC_SLOT_ILL)
      else $error("slot illegal not on its vector");

   por_done_c: cover property (
      state_q == cxe_pkg::ST_RST_STACK && mem_done ##1 fetch_start_q);
   irq_entry_c: cover property (irq_take ##[3:40] fetch_start_q);
   trap_entry_c: cover property (exc_go && trap_go && !irq_go);
   wd_clash_c: cover property (watchdog_overflow && por_rise);
endmodule : cxe_entry

// ---- dv/cxe_mem_model.sv ----
`timescale 1ns/1ps
module cxe_mem_model
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // memory port of the entry block
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack,
   // stall select
   input wire logic slow
);
   logic [1:0] wait_q;
   logic [31:0] last_q;
   logic [64:0] log_q[$];
   // =============================================
   // table words are a pure function of the address
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return {~a[15:0], a[15:0]};
   endfunction : word_at
   // slow mode stalls every request two cycles
   assign mem_ack = mem_req && (!slow || wait_q == 2'h2);
   // idle bus shows the inverse of the last word, never a stale copy
   assign mem_rdata = mem_ack ? word_at(mem_addr) : ~last_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wait_q <= 2'h0;
         last_q <= 32'h00000000;
      end
      else
      begin
         wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
         if (mem_ack)
            last_q <= mem_rdata;
      end
   end
   // transaction log for the bench
   always @(posedge pclk)
   begin
      if (mem_ack)
         log_q.push_back({mem_we, mem_addr, mem_we ? mem_wdata : mem_rdata});
   end
endmodule : cxe_mem_model

// ---- dv/cpu_exception_entry_tb.sv ----
`timescale 1ns/1ps
`include "cxe_params.svh"
module cpu_exception_entry_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, return_addr, mem_rdata, mem_addr;
   logic [31:0] mem_wdata, fetch_addr, lfsr_q;
   logic power_on_reset_pin_n, manual_reset_pin_n, watchdog_overflow;
   logic watchdog_flag_clear, bus_cycle_busy, irq_req, irq_ack, dec_valid;
   logic dec_undefined, dec_in_slot, dec_flow_write, dec_trap, prev_done;
   logic addr_err_cpu, addr_err_xfer, mem_req, mem_we, mem_ack;
   logic fetch_start, slow;
   logic [3:0] irq_level;
   logic [7:0] irq_vector, dec_trap_imm;
   int bad_count, checks;
   int acks = 0;
   always @(posedge pclk)
      if (irq_ack === 1'b1)
         acks <= acks + 1;
   cxe_entry u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .power_on_reset_pin_n,
      .manual_reset_pin_n, .watchdog_overflow, .watchdog_flag_clear,
      .bus_cycle_busy, .irq_req, .irq_level, .irq_vector, .irq_ack,
      .dec_valid, .dec_undefined, .dec_in_slot, .dec_flow_write, .dec_trap,
      .dec_trap_imm, .addr_err_cpu, .addr_err_xfer, .prev_done,
      .return_addr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
      .mem_ack, .fetch_start, .fetch_addr);
   cxe_mem_model u_mem (.pclk, .presetn, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_rdata, .mem_ack, .slow);
   // =============================================
   // helpers
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q;
   endfunction : rnd
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return {~a[15:0], a[15:0]};
   endfunction : word_at
   function automatic logic [7:0] exp_vec(input int k, input logic [7:0] t,
                                          input logic [7:0] iv);
      case (k)
         0: return 8'h20 + {3'h0, t[4:0]};
         1: return 8'h04;
         2, 3: return 8'h06;
         4: return 8'h09;
         5: return 8'h0a;
         default: return iv;
      endcase
   endfunction : exp_vec
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // apb master: no cycle count assumed, waits for pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = pslverr ? 32'hdead0000 : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wait_fetch();
      int n;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (fetch_start !== 1'b1 && n < 300);
      chk("fetch start", {31'h0, fetch_start}, 32'h1);
   endtask : wait_fetch
   task automatic chk_log(input int i, input logic w, input logic [31:0] a, d);
      logic [64:0] e;
      e = (i < u_mem.log_q.size()) ? u_mem.log_q[i] : 65'h0;
      chk("mem dir", {31'h0, e[64]}, {31'h0, w});
      chk("mem addr", e[63:32], a);
      chk("mem data", e[31:0], d);
   endtask : chk_log
   task automatic chk_reset(input logic [31:0] b);
      logic [31:0] r;
      wait_fetch();
      chk("log size", u_mem.log_q.size(), 32'h2);
      chk_log(0, 1'b0, b, word_at(b));
      chk_log(1, 1'b0, b + 32'h4, word_at(b + 32'h4));
      chk("fetch addr", fetch_addr, word_at(b));
      apb(1'b0, `CXE_OFF_STACK_PTR, 32'h0, r);
      chk("stack", r, word_at(b + 32'h4));
      apb(1'b0, `CXE_OFF_VECTOR_BASE, 32'h0, r);
      chk("vbase", r, 32'h0);
      apb(1'b0, `CXE_OFF_STATUS_WORD, 32'h0, r);
      chk("mask", r & 32'hf0, 32'hf0);
      u_mem.log_q.delete();
      $display("reset test at %h done", b);
   endtask : chk_reset
   // =============================================
   // one non-reset entry of kind k
   task automatic exc(input int k);
      logic [31:0] r, sp, vb, ret, x;
      logic [3:0] m, lv;
      logic [7:0] v;
      int a0;
      a0 = acks;
      r = rnd();
      ret = rnd();
      sp = {16'h0001, r[15:2], 2'h0};
      vb = {20'h0, r[27:18], 2'h0};
      m = (k == 6 && r[31:28] == 4'hf) ? 4'he : r[31:28];
      lv = 4'(int'(m) + 1 + int'(r[1:0]) % (15 - int'(m)));
      v = 8'h48 + 8'(r[23:16] % 184);
      apb(1'b1, `CXE_OFF_STATUS_WORD, {24'h0, m, 4'h0}, x);
      apb(1'b1, `CXE_OFF_VECTOR_BASE, vb, x);
      apb(1'b1, `CXE_OFF_STACK_PTR, sp, x);
      return_addr <= ret;
      slow <= r[8];
      dec_trap_imm <= r[23:16];
      dec_valid <= k < 4;
      dec_trap <= k == 0;
      dec_undefined <= k == 1 || k == 2;
      dec_in_slot <= k == 2 || k == 3;
      dec_flow_write <= k == 3;
      irq_req <= k == 6;
      irq_level <= lv;
      irq_vector <= v;
      if (k == 4 || k == 5)
      begin
         prev_done <= 1'b0;
         addr_err_cpu <= k == 4;
         addr_err_xfer <= k == 5;
         @(posedge pclk);
         addr_err_cpu <= 1'b0;
         addr_err_xfer <= 1'b0;
         repeat (3) @(posedge pclk);
         chk("early entry", {31'h0, mem_req}, 32'h0);
         prev_done <= 1'b1;
      end
      @(posedge pclk);
      {dec_valid, dec_trap, dec_undefined, dec_in_slot, irq_req} <= 5'h0;
      dec_flow_write <= 1'b0;
      wait_fetch();
      x = vb + {22'h0, exp_vec(k, r[23:16], v), 2'h0};
      chk("log size", u_mem.log_q.size(), 32'h3);
      chk("irq ack", acks - a0, (k == 6) ? 32'h1 : 32'h0);
      chk_log(0, 1'b1, sp - 32'h4, {24'h0, m, 4'h0});
      chk_log(1, 1'b1, sp - 32'h8, ret);
      chk_log(2, 1'b0, x, word_at(x));
      chk("handler", fetch_addr, word_at(x));
      apb(1'b0, `CXE_OFF_STATUS_WORD, 32'h0, x);
      chk("mask", x & 32'hf0, {24'h0, (k == 6) ? lv : m, 4'h0});
      apb(1'b0, `CXE_OFF_STACK_PTR, 32'h0, x);
      chk("stack", x, sp - 32'h8);
      u_mem.log_q.delete();
      $display("entry kind %0d done", k);
   endtask : exc
   // =============================================
   // clock, watchdog and main sequence
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      $display("watchdog expired");
      tally_and_finish();
   end
   initial
   begin
      logic [31:0] r;
      logic e;
      lfsr_q = 32'h00000056;
      {presetn, psel, penable, pwrite, paddr, pwdata, return_addr} = '0;
      {watchdog_overflow, bus_cycle_busy, irq_req, irq_level} = '0;
      {irq_vector, dec_valid, dec_undefined, dec_in_slot} = '0;
      {dec_flow_write, dec_trap, dec_trap_imm, addr_err_cpu} = '0;
      {addr_err_xfer, slow} = '0;
      {power_on_reset_pin_n, manual_reset_pin_n, prev_done} = 3'h7;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk_reset(32'h0);
      apb(1'b0, 12'h100, 32'h0, r);
      chk("unmapped", r, 32'hdead0000);
      for (int i = 0; i < 21; i++)
         exc(i % 7);
      watchdog_overflow <= 1'b1;
      @(posedge pclk);
      watchdog_overflow <= 1'b0;
      chk_reset(32'h0);
      power_on_reset_pin_n <= 1'b0;
      repeat (4) @(posedge pclk);
      watchdog_overflow <= 1'b1;
      @(posedge pclk);
      watchdog_overflow <= 1'b0;
      e = 1'b0;
      repeat (4)
      begin
         @(posedge pclk);
         e = e | (watchdog_flag_clear === 1'b1);
      end
      chk("flag clear", {31'h0, e}, 32'h1);
      power_on_reset_pin_n <= 1'b1;
      chk_reset(32'h0);
      // manual entry must wait for the foreign bus cycle
      apb(1'b1, `CXE_OFF_VECTOR_BASE, 32'h00000100, r);
      manual_reset_pin_n <= 1'b0;
      bus_cycle_busy <= 1'b1;
      repeat (4) @(posedge pclk);
      manual_reset_pin_n <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("busy hold", {31'h0, mem_req}, 32'h0);
      bus_cycle_busy <= 1'b0;
      chk_reset(32'h8);
      tally_and_finish();
   end
endmodule : cpu_exception_entry_tb
